// ==== logic/tcs_defines.vh ====
// Operation
// - channel X code 001 counts every system clock cycle
// - channel X code 010 counts falling edge of clock divided by two
// - channel X code 011 counts falling edge of clock divided by four
// - channel Y code 001 counts falling edge of clock divided by four
// - channel Y code 010 counts falling edge of clock divided by 256
// - channel Y code 011 counts falling edge of clock divided by 2048
// - codes 000 and 100 stop counting; 000 after reset
// - code 101 counts rising edges of external clock
// - code 110 counts falling edges of external clock
// - code 111 counts both edges of external clock
`ifndef TCS_DEFINES_VH
`define TCS_DEFINES_VH

`define TCS_SEL_W        3
`define TCS_SEL_OFF      3'h0
`define TCS_SEL_INT_A    3'h1
`define TCS_SEL_INT_B    3'h2
`define TCS_SEL_INT_C    3'h3
`define TCS_SEL_OFF2     3'h4
`define TCS_SEL_EXT_RISE 3'h5
`define TCS_SEL_EXT_FALL 3'h6
`define TCS_SEL_EXT_BOTH 3'h7
`define TCS_SEL_RESET    3'h0

`define TCS_PRE_W        11
`define TCS_X_DIV_B      2
`define TCS_X_DIV_C      4
`define TCS_Y_DIV_A      4
`define TCS_Y_DIV_B      256
`define TCS_Y_DIV_C      2048

`endif

// ==== logic/tcs_count_clock_select.v ====
`timescale 1ns/100ps
`include "tcs_defines.vh"

module tcs_count_clock_select #(
    parameter PRE_W = `TCS_PRE_W
) (
    // clock and reset
    input  wire                    clock,
    input  wire                    rst,
    // channel x select and external clock
    input  wire [`TCS_SEL_W-1:0]   x_count_source_sel,
    input  wire                    x_ext_clk,
    // channel y select and external clock
    input  wire [`TCS_SEL_W-1:0]   y_count_source_sel,
    input  wire                    y_ext_clk,
    // increment strobes to the counters
    output reg                     x_count_inc,
    output reg                     y_count_inc
);

////////////////////////////////////////////////////////////////////////////////
// free-running prescaler; bit n models clock/2^(n+1)
// select changes apply from the next edge, with no settling gap

reg  [PRE_W-1:0] prescale;
wire [PRE_W-1:0] next_prescale;

assign next_prescale = prescale + {{(PRE_W-1){1'h0}}, 1'h1};

// cleared by reset so every divided rate starts in a known phase
always @(posedge clock) begin
    if (rst) begin
        prescale <= {PRE_W{1'h0}};
    end else begin
        prescale <= next_prescale;
    end
end

////////////////////////////////////////////////////////////////////////////////
// decode helpers shared by both channels
// shared so the two channels' decode cannot drift apart

// falling edge of clock/div: the divided clock bit drops exactly when all
// lower bits and that bit wrap, i.e. count reaches div-1
// limitation: div must be a power of two no larger than 2^PRE_W
function fall_tick;
    input [PRE_W-1:0] cnt;
    input integer     div;
    integer           span;
    reg   [PRE_W-1:0] mask;
    begin
        span      = div - 1;
        mask      = span[PRE_W-1:0];
        fall_tick = ((cnt & mask) == mask);
    end
endfunction

// codes that block every count clock
function sel_stopped;
    input [`TCS_SEL_W-1:0] sel;
    begin
        case (sel)
            `TCS_SEL_OFF: begin
                sel_stopped = 1'h1;
            end
            `TCS_SEL_OFF2: begin
                sel_stopped = 1'h1;
            end
            default: begin
                sel_stopped = 1'h0;
            end
        endcase
    end
endfunction

// codes that count the external pin rather than the prescaler
function sel_external;
    input [`TCS_SEL_W-1:0] sel;
    begin
        case (sel)
            `TCS_SEL_EXT_RISE: begin
                sel_external = 1'h1;
            end
            `TCS_SEL_EXT_FALL: begin
                sel_external = 1'h1;
            end
            `TCS_SEL_EXT_BOTH: begin
                sel_external = 1'h1;
            end
            default: begin
                sel_external = 1'h0;
            end
        endcase
    end
endfunction

// pick the pin edge that the code asks for
function ext_tick;
    input [`TCS_SEL_W-1:0] sel;
    input                  rise;
    input                  fall;
    begin
        case (sel)
            `TCS_SEL_EXT_RISE: begin
                ext_tick = rise;
            end
            `TCS_SEL_EXT_FALL: begin
                ext_tick = fall;
            end
            `TCS_SEL_EXT_BOTH: begin
                ext_tick = rise | fall;
            end
            // stop and prescaler codes give no pin edge
            default: begin
                ext_tick = 1'h0;
            end
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// divided-clock falling edges, one enable tap per rate

wire x_tap_b;
wire x_tap_c;
wire y_tap_a;
wire y_tap_b;
wire y_tap_c;

assign x_tap_b = fall_tick(prescale, `TCS_X_DIV_B);
assign x_tap_c = fall_tick(prescale, `TCS_X_DIV_C);
assign y_tap_a = fall_tick(prescale, `TCS_Y_DIV_A);
assign y_tap_b = fall_tick(prescale, `TCS_Y_DIV_B);
assign y_tap_c = fall_tick(prescale, `TCS_Y_DIV_C);

////////////////////////////////////////////////////////////////////////////////
// external clock synchronisers and edge detect

// two sync stages plus one stage of edge history
reg [2:0] x_sync;
reg [2:0] y_sync;

// x pin sync
// a pin held high through reset shows one rise after release
always @(posedge clock) begin
    if (rst) begin
        x_sync <= 3'h0;
    end else begin
        x_sync <= {x_sync[1:0], x_ext_clk};
    end
end

always @(posedge clock) begin
    if (rst) begin
        y_sync <= 3'h0;
    end else begin
        y_sync <= {y_sync[1:0], y_ext_clk};
    end
end

// edges read stages 1 and 2 only, never the first flop
wire x_rise;
wire x_fall;
wire y_rise;
wire y_fall;

assign x_rise = x_sync[1] & ~x_sync[2];
assign x_fall = ~x_sync[1] & x_sync[2];
assign y_rise = y_sync[1] & ~y_sync[2];
assign y_fall = ~y_sync[1] & y_sync[2];

// pulses shorter than two clocks per level can be lost
wire x_ext_tick;
wire y_ext_tick;

assign x_ext_tick = ext_tick(x_count_source_sel, x_rise, x_fall);
assign y_ext_tick = ext_tick(y_count_source_sel, y_rise, y_fall);

////////////////////////////////////////////////////////////////////////////////
// internal rate selection per channel
// x rates: full, /2, /4; y rates: /4, /256, /2048

reg x_int_tick;
reg y_int_tick;

always @* begin
    case (x_count_source_sel)
        `TCS_SEL_INT_A: begin
            x_int_tick = 1'h1;
        end
        `TCS_SEL_INT_B: begin
            x_int_tick = x_tap_b;
        end
        `TCS_SEL_INT_C: begin
            x_int_tick = x_tap_c;
        end
        // stop and external codes fall through to zero
        default: begin
            x_int_tick = 1'h0;
        end
    endcase
end

always @* begin
    case (y_count_source_sel)
        `TCS_SEL_INT_A: begin
            y_int_tick = y_tap_a;
        end
        `TCS_SEL_INT_B: begin
            y_int_tick = y_tap_b;
        end
        `TCS_SEL_INT_C: begin
            y_int_tick = y_tap_c;
        end
        // stop and external codes fall through to zero
        default: begin
            y_int_tick = 1'h0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// source class per channel
// code 100 sits beside the prescaler codes, so it is caught here first

wire x_stopped;
wire x_external;
wire y_stopped;
wire y_external;

assign x_stopped  = sel_stopped(x_count_source_sel);
assign x_external = sel_external(x_count_source_sel);
assign y_stopped  = sel_stopped(y_count_source_sel);
assign y_external = sel_external(y_count_source_sel);

////////////////////////////////////////////////////////////////////////////////
// final choice: stopped, external pin or internal rate
// external codes never see the prescaler taps

reg next_x_inc;
reg next_y_inc;

always @* begin
    if (x_stopped) begin
        next_x_inc = 1'h0;
    end else if (x_external) begin
        next_x_inc = x_ext_tick;
    end else begin
        next_x_inc = x_int_tick;
    end
end

always @* begin
    if (y_stopped) begin
        next_y_inc = 1'h0;
    end else if (y_external) begin
        next_y_inc = y_ext_tick;
    end else begin
        next_y_inc = y_int_tick;
    end
end

////////////////////////////////////////////////////////////////////////////////
// registered strobes: one cycle latency, single-cycle wide except under x code 001
// the flop keeps decode glitches off the counters
// x code 001 holds the strobe high in every cycle

always @(posedge clock) begin
    if (rst) begin
        x_count_inc <= 1'h0;
    end else begin
        x_count_inc <= next_x_inc;
    end
end

always @(posedge clock) begin
    if (rst) begin
        y_count_inc <= 1'h0;
    end else begin
        y_count_inc <= next_y_inc;
    end
end

endmodule

// ==== tb/tcs_props.sv ====
`timescale 1ns/100ps
module tcs_props #(
    parameter PRE_W = 11
) (
    // clock and reset
    input logic       clock,
    input logic       rst,
    // channel x
    input logic [2:0] x_count_source_sel,
    input logic       x_ext_clk,
    input logic       x_count_inc,
    // channel y
    input logic [2:0] y_count_source_sel,
    input logic       y_ext_clk,
    input logic       y_count_inc
);
    wire [2:0] xs = x_count_source_sel;
    wire [2:0] ys = y_count_source_sel;
    wire       xi = x_count_inc;
    wire       yi = y_count_inc;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_xf; !$past(rst) && $past(xs) == 3'h1 |-> xi; endproperty
    property p_x2; xi && $past(xs) == 3'h2 |=> !xi ##1 xi; endproperty
    property p_x4; xi && $past(xs) == 3'h3 |=> !xi [*3] ##1 xi; endproperty
    property p_y4; yi && $past(ys) == 3'h1 |=> !yi [*3] ##1 yi; endproperty
    property p_off; (($past(xs) & 3'h3) == 3'h0 |-> !xi) and (($past(ys) & 3'h3) == 3'h0 |-> !yi);
    endproperty
    property p_xr; $rose(x_ext_clk) && xs == 3'h5 |-> ##[1:4] xi; endproperty
    property p_yf; $fell(y_ext_clk) && ys == 3'h6 |-> ##[1:4] yi; endproperty
    property p_xb; $changed(x_ext_clk) && xs == 3'h7 |-> ##[1:4] xi; endproperty
    a_xf: assert property (p_xf) else $error("x stalled");
    a_x2: assert property (p_x2) else $error("x half rate");
    a_x4: assert property (p_x4) else $error("x quarter rate");
    a_y4: assert property (p_y4) else $error("y quarter rate");
    a_off: assert property (p_off) else $error("count while off");
    a_xr: assert property (p_xr) else $error("x rise lost");
    a_yf: assert property (p_yf) else $error("y fall lost");
    a_xb: assert property (p_xb) else $error("x edge lost");
    c_y: cover property (yi && ys == 3'h3);
    c_x: cover property (xi && xs == 3'h7);
    c_h: cover property (xi && xs == 3'h2);
endmodule
bind tcs_count_clock_select tcs_props #(.PRE_W(PRE_W)) props_u (.clock, .rst, .x_ext_clk,
    .y_ext_clk, .x_count_inc, .y_count_inc, .x_count_source_sel, .y_count_source_sel);

// ==== tb/tcs_ext_clk_model.sv ====
`timescale 1ns/100ps
module tcs_ext_clk_model (
    output logic ext_clk
);
    // each channel has its own pin; nothing chains one channel to the other
    initial ext_clk = 1'h0;
    // four cycles a level so the two-flop sampler never misses one
    task automatic edges(input int n);
        repeat (n) #200 ext_clk = ~ext_clk;
    endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    logic       clock, rst, x_inc, y_inc;
    logic [2:0] x_sel, y_sel;
    wire        x_ext, y_ext;
    int         miscompares, comparisons;
    tcs_count_clock_select dut_u (.clock(clock), .rst(rst), .x_count_source_sel(x_sel),
        .x_ext_clk(x_ext), .y_count_source_sel(y_sel), .y_ext_clk(y_ext),
        .x_count_inc(x_inc), .y_count_inc(y_inc));
    tcs_ext_clk_model xm (.ext_clk(x_ext));
    tcs_ext_clk_model ym (.ext_clk(y_ext));
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    task automatic check(input int got, exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // 4N+1 cycles hold four strobes whether the first lands at N or N+1
    task automatic run(input logic [2:0] xs, ys, input int nx, ny, ne, output int cx, cy);
        rst = 1'h1;
        x_sel = xs;
        y_sel = ys;
        repeat (10) @(negedge clock);
        rst = 1'h0;
        cx = 0;
        cy = 0;
        fork
            xm.edges(ne);
            ym.edges(ne);
            for (int i = 1; i <= (nx > ny ? nx : ny); i++) begin
                @(negedge clock);
                cx += int'(i <= nx && x_inc === 1'h1);
                cy += int'(i <= ny && y_inc === 1'h1);
            end
        join
    endtask
    task automatic s_internal;
        int cx, cy;
        run(3'h1, 3'h1, 5, 17, 0, cx, cy);
        // full rate strobes in every one of the five cycles
        check(cx, 5);
        check(cy, 4);
        run(3'h2, 3'h2, 9, 1025, 0, cx, cy);
        check(cx, 4);
        check(cy, 4);
        run(3'h3, 3'h3, 17, 8193, 0, cx, cy);
        check(cx, 4);
        check(cy, 4);
    endtask
    task automatic s_external;
        int cx, cy;
        run(3'h5, 3'h6, 40, 40, 4, cx, cy);
        check(cx, 2);
        check(cy, 2);
        run(3'h6, 3'h5, 40, 40, 4, cx, cy);
        check(cx, 2);
        check(cy, 2);
        run(3'h7, 3'h7, 40, 40, 4, cx, cy);
        check(cx, 4);
        check(cy, 4);
        run(3'h4, 3'h0, 40, 40, 4, cx, cy);
        check(cx, 0);
        check(cy, 0);
        run(3'h0, 3'h4, 40, 40, 4, cx, cy);
        check(cx, 0);
        check(cy, 0);
    endtask
    initial begin
        #1000000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        s_internal;
        s_external;
        report_and_stop;
    end
endmodule
